// ### pkg/brtr_defs.vh
// Purpose: Constants for the bit-reversal and table-read address unit.
// Assumes: Included by the unit's single design file.
// Notes:   Offsets are word indexes on the plain register port.
`ifndef BRTR_DEFS_VH
`define BRTR_DEFS_VH
`define BRTR_OFF_CTRL      4'h0
`define BRTR_OFF_MODE      4'h1
`define BRTR_OFF_PAGE      4'h2
`define BRTR_OFF_LASTEA    4'h3
`define BRTR_OFF_TBLADDR   4'h4
`define BRTR_CTRL_EN_BIT   15
`define BRTR_CTRL_RST      16'h0000
`define BRTR_MODE_RST      16'h0F00
`define BRTR_PAGE_RST      8'h00
`define BRTR_SEL_LO        11
`define BRTR_SEL_HI        8
`define BRTR_SEL_NONE      4'hF
`define BRTR_AM_POSTINC    3'h3
`define BRTR_AM_PREINC     3'h5
`endif

// ### verilog/brtr_agu.v
// Purpose: Bit-reversed write address generation on the X write path and
//          program-space address and data shaping for table reads.
// Assumes: Single clock mclk at 100 MHz, synchronous active-high rst.
// Notes:   Address and table results stand one cycle after their request.
//          The pointer file and modulo logic live outside; this unit only
//          overrides their ordinary result when reversal applies.
`timescale 1ns/10ps
`include "brtr_defs.vh"

// Notes on behaviour
// - Reversal only on X generator data writes, never reads or Y.
// - Only the modifier is bit-reversed; pointer stays normal order.
// - Active when select not 1111, enable set, pre/post-increment mode.
// - A 15-bit reversal pivot is held, usually half the buffer size.
// - Word data only; pivot scaled to bytes, address LSB forced zero.
// - Other modes or byte writes produce ordinary addresses.
// - While active, pointer plus pivot; normal increment offset ignored.
// - Reversal takes priority over modulo on the same pointer.
// - 16-entry buffer yields 4-bit reversed index order.
// - Program word is 24 bits, data word 16, data may sit in program.
// - Remap window is read-only and shows only the low 16 bits.
// - Program-space address LSB is fixed at zero.
// - Unaligned table operations and configuration reads are accepted.
// - Word low read returns program bits 15 to 0.
// - Byte low read: select 1 upper byte, select 0 lower byte.
// - Word high read: bits 23 to 16 low, high byte zero.
// - Byte high read: zero when select is 1, else upper byte.
// - Table address is page byte over the 16-bit effective address.
module brtr_agu #(
   parameter PW = 24,
   parameter DW = 16
) (
   input  wire          mclk,
   input  wire          rst,
   input  wire [3:0]    regAddr,
   input  wire [15:0]   regWrData,
   input  wire          regWrStb,
   input  wire          regRdStb,
   output reg  [15:0]   regRdData,
   input  wire          eaReq,
   input  wire          eaIsWrite,
   input  wire          eaIsXGen,
   input  wire          eaIsByte,
   input  wire [2:0]    eaAddrMode,
   input  wire [3:0]    eaPtrSel,
   input  wire [15:0]   eaPtrValue,
   input  wire [15:0]   eaNormalEa,
   input  wire [15:0]   eaNormalPtrNext,
   output reg           eaValid,
   output reg  [15:0]   eaOut,
   output reg           eaPtrWrEn,
   output reg  [3:0]    eaPtrWrSel,
   output reg  [15:0]   eaPtrWrData,
   output reg           eaRevUsed,
   input  wire          tblReq,
   input  wire          tblHigh,
   input  wire          tblByte,
   input  wire [15:0]   tblEa,
   output reg  [PW-1:0] tblAddr,
   input  wire [PW-1:0] progWord,
   output reg           tblValid,
   output reg  [DW-1:0] tblData,
   input  wire          winReq,
   input  wire          winWrite,
   output reg           winValid,
   output reg           winRefused,
   output reg  [DW-1:0] winData
);

   reg  [15:0]   bitReverseControl_reg;
   reg  [15:0]   addressModeControl_reg;
   reg  [7:0]    tablePage_reg;
   reg  [15:0]   lastEa_reg;
   reg  [PW-1:0] tblAddrHold_reg;
   reg  [15:0]   regRdData_next;
   reg  [15:0]   revSum;
   reg  [PW-1:0] tblAddr_next;
   reg  [DW-1:0] tblData_next;
   wire [3:0]    reversalPointerSelect;
   wire          reversalEnable;
   wire [15:0]   pivotBytes;
   wire          incMode;
   wire          revActive;
   wire          wrCtrl;
   wire          wrMode;
   wire          wrPage;
   wire [15:0]   eaChosen;
   wire [15:0]   ptrChosen;

   // Reverse-carry addition: reverse both operands, add, reverse back.
   function [15:0] revAdd;
      input [15:0] a;
      input [15:0] b;
      reg   [15:0] ra;
      reg   [15:0] rb;
      reg   [15:0] rs;
      integer      i;
      begin
         ra = 16'h0000;
         rb = 16'h0000;
         for (i = 0; i < 16; i = i + 1) begin
            ra[15-i] = a[i];
            rb[15-i] = b[i];
         end
         rs = ra + rb;
         revAdd = 16'h0000;
         for (i = 0; i < 16; i = i + 1) begin
            revAdd[i] = rs[15-i];
         end
      end
   endfunction

   // Program-space address: page byte over the word-aligned effective
   // address. Bit 0 is dropped here so every consumer sees the same
   // aligned address, whether or not a byte lane is being selected.
   function [23:0] progAddr;
      input [7:0]  page;
      input [15:0] ea;
      begin
         progAddr = {page, ea[15:1], 1'b0};
      end
   endfunction

   // Byte lane pick for byte-mode reads; the high lane answers when
   // the select bit is set. The result is zero-extended to a data word.
   function [15:0] laneByte;
      input [15:0] word;
      input        pickHigh;
      begin
         laneByte = {8'h00, pickHigh ? word[15:8] : word[7:0]};
      end
   endfunction

   // Select and enable fields; the pivot is scaled to a byte offset.
   assign reversalPointerSelect =
      addressModeControl_reg[`BRTR_SEL_LO:`BRTR_SEL_HI];
   assign reversalEnable = bitReverseControl_reg[`BRTR_CTRL_EN_BIT];
   assign pivotBytes = {bitReverseControl_reg[14:0], 1'b0};
   assign incMode = (eaAddrMode == `BRTR_AM_POSTINC) ||
                    (eaAddrMode == `BRTR_AM_PREINC);
   // Reversal overrides modulo because it replaces the normal path.
   assign revActive = (reversalPointerSelect != `BRTR_SEL_NONE) &&
                      reversalEnable && incMode &&
                      (eaPtrSel == reversalPointerSelect) &&
                      eaIsWrite && eaIsXGen && !eaIsByte;

   // Reversed sum of pointer and modifier, LSB held clear.
   always @* begin
      revSum = revAdd({eaPtrValue[15:1], 1'b0}, pivotBytes);
      revSum[0] = 1'b0;
   end

   // Address and pointer update chosen between the reversed path and
   // the ordinary path. Post-increment hands out the old pointer and
   // pre-increment the updated one; either way the pointer takes sum.
   assign eaChosen = !revActive ? eaNormalEa
                   : (eaAddrMode == `BRTR_AM_PREINC) ? revSum
                   : {eaPtrValue[15:1], 1'b0};
   assign ptrChosen = revActive ? revSum : eaNormalPtrNext;

   // Write decode per register; unmapped and read-only indexes drop.
   assign wrCtrl = regWrStb && (regAddr == `BRTR_OFF_CTRL);
   assign wrMode = regWrStb && (regAddr == `BRTR_OFF_MODE);
   assign wrPage = regWrStb && (regAddr == `BRTR_OFF_PAGE);

   // Register read mux, decoded by address.
   always @* begin
      regRdData_next = 16'h0000;
      if (regAddr == `BRTR_OFF_CTRL) begin
         regRdData_next = bitReverseControl_reg;
      end else if (regAddr == `BRTR_OFF_MODE) begin
         regRdData_next = addressModeControl_reg;
      end else if (regAddr == `BRTR_OFF_PAGE) begin
         regRdData_next = {8'h00, tablePage_reg};
      end else if (regAddr == `BRTR_OFF_LASTEA) begin
         regRdData_next = lastEa_reg;
      end else if (regAddr == `BRTR_OFF_TBLADDR) begin
         regRdData_next = tblAddrHold_reg[15:0];
      end
   end

   // Table address and read-data shaping. A low read hands out the
   // low program word or one of its bytes; a high read hands out the
   // top byte, or zero for a byte read with select 1, and the missing
   // upper data byte always reads as zero.
   always @* begin
      tblAddr_next = progAddr(tablePage_reg, tblEa);
      tblData_next = {DW{1'b0}};
      if (!tblHigh && !tblByte) begin
         tblData_next = progWord[15:0];
      end else if (!tblHigh) begin
         tblData_next = laneByte(progWord[15:0], tblEa[0]);
      end else if (!tblByte) begin
         tblData_next = {8'h00, progWord[23:16]};
      end else begin
         tblData_next = laneByte({8'h00, progWord[23:16]},
                                 tblEa[0]);
      end
   end

   // Read data stands for one cycle after the read strobe and is zero
   // otherwise, so a stray capture by the master never sees old data.
   always @(posedge mclk) begin
      if (rst) begin
         regRdData <= 16'h0000;
      end else if (regRdStb) begin
         regRdData <= regRdData_next;
      end else begin
         regRdData <= 16'h0000;
      end
   end

   // Reversal control: enable in the top bit, pivot below it. A new
   // pivot acts on the very next request, which is why software must
   // not read through the reversal pointer right after rewriting it.
   always @(posedge mclk) begin
      if (rst) begin
         bitReverseControl_reg <= `BRTR_CTRL_RST;
      end else if (wrCtrl) begin
         bitReverseControl_reg <= regWrData;
      end
   end

   // Address mode control; its reset value parks the pointer select at
   // the all-ones code, which keeps reversal off until software acts.
   always @(posedge mclk) begin
      if (rst) begin
         addressModeControl_reg <= `BRTR_MODE_RST;
      end else if (wrMode) begin
         addressModeControl_reg <= regWrData;
      end
   end

   // Table page: the upper byte of every program-space address.
   always @(posedge mclk) begin
      if (rst) begin
         tablePage_reg <= `BRTR_PAGE_RST;
      end else if (wrPage) begin
         tablePage_reg <= regWrData[7:0];
      end
   end

   // Effective address result and pointer write-back. Strobes follow
   // the request by one cycle; eaOut and eaPtrWrData hold between requests, eaPtrWrSel follows eaPtrSel every cycle.
   always @(posedge mclk) begin
      if (rst) begin
         eaValid     <= 1'b0;
         eaOut       <= 16'h0000;
         eaPtrWrEn   <= 1'b0;
         eaPtrWrSel  <= 4'h0;
         eaPtrWrData <= 16'h0000;
         eaRevUsed   <= 1'b0;
         lastEa_reg  <= 16'h0000;
      end else begin
         eaValid    <= eaReq;
         eaPtrWrEn  <= eaReq && incMode;
         eaPtrWrSel <= eaPtrSel;
         eaRevUsed  <= eaReq && revActive;
         if (eaReq) begin
            eaOut       <= eaChosen;
            eaPtrWrData <= ptrChosen;
            lastEa_reg  <= eaChosen;
         end
      end
   end

   // Table read results. The address output follows the effective
   // address every cycle; data and the held copy move only on request.
   always @(posedge mclk) begin
      if (rst) begin
         tblAddr         <= {PW{1'b0}};
         tblAddrHold_reg <= {PW{1'b0}};
         tblValid        <= 1'b0;
         tblData         <= {DW{1'b0}};
      end else begin
         tblAddr  <= progAddr(tablePage_reg, tblEa);
         tblValid <= tblReq;
         if (tblReq) begin
            tblData         <= tblData_next;
            tblAddrHold_reg <= tblAddr_next;
         end
      end
   end

   // Program window: reads see only the low program word; writes are
   // refused and leave the held data untouched.
   always @(posedge mclk) begin
      if (rst) begin
         winValid   <= 1'b0;
         winRefused <= 1'b0;
         winData    <= {DW{1'b0}};
      end else begin
         winValid   <= winReq && !winWrite;
         winRefused <= winReq && winWrite;
         if (winReq && !winWrite) begin
            winData <= progWord[15:0];
         end
      end
   end

endmodule // brtr_agu

// ### test/brtr_agu_props.sv
// Purpose: Port checks of the address unit.
// Assumes: Answers come one cycle after each request.
// Notes:   Bound to every instance.
`timescale 1ns/10ps
module brtr_agu_props #(parameter PW = 24, DW = 16) (
   input wire          mclk, rst, eaReq, eaIsXGen, eaIsByte, eaValid,
   input wire          eaRevUsed, tblReq, tblHigh, tblByte, tblValid,
   input wire          winReq, winWrite, winValid, winRefused,
   input wire [2:0]    eaAddrMode,
   input wire [15:0]   eaNormalEa, eaOut, tblEa,
   input wire [PW-1:0] tblAddr, progWord,
   input wire [DW-1:0] tblData
);
   // Checks run on the core clock and rest in reset.
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_ea_ordinary: assert property (eaReq && !eaIsXGen |=> eaValid &&
      eaOut == $past(eaNormalEa)) else $error("Y EA altered.");
   a_no_rev_byte: assert property (eaReq && eaIsByte |=> !eaRevUsed)
      else $error("Byte reversed.");
   a_no_rev_mode: assert property (eaReq && eaAddrMode != 3 &&
      eaAddrMode != 5 |=> !eaRevUsed) else $error("Mode reversed.");
   a_tbl_addr: assert property (tblReq |=> tblValid &&
      tblAddr[15:0] == {$past(tblEa[15:1]), 1'b0}) else $error("Addr.");
   a_low_word: assert property (tblReq && !tblHigh && !tblByte |=>
      tblData == $past(progWord[15:0])) else $error("Low word.");
   a_high_word: assert property (tblReq && tblHigh && !tblByte |=>
      tblData == $past(progWord[23:16])) else $error("High word.");
   a_high_zero: assert property (tblReq && tblHigh && tblByte
      && tblEa[0] |=> tblData == 0) else $error("Phantom byte.");
   a_win_refuse: assert property (winReq && winWrite |=> winRefused
      && !winValid) else $error("Window write.");
endmodule // brtr_agu_props
bind brtr_agu brtr_agu_props #(.PW(PW), .DW(DW)) chk_u (.*);

// ### test/brtr_prog_mem.sv
// Purpose: Stand-in program memory.
// Assumes: Combinational read.
// Notes:   Content is a scramble of the address.
`timescale 1ns/10ps
module brtr_prog_mem (
   input  wire [23:0] progAddr,
   output wire [23:0] progWord
);
   // Every address, configuration space too, holds a 24-bit word.
   assign progWord = progAddr * 24'h00A3B7 ^ 24'h5C1E93;
endmodule // brtr_prog_mem

// ### test/brtr_agu_tb_top.sv
// Purpose: Self-checking bench of the address unit.
// Assumes: The model below gives every expected value.
// Notes:   Seeded random stimulus.
`timescale 1ns/10ps
module brtr_agu_tb_top;
   reg         mclk = 0, rst = 1, regWrStb = 0, regRdStb = 0, eaReq = 0;
   reg         eaIsWrite = 0, eaIsXGen = 0, eaIsByte = 0, tblReq = 0;
   reg         tblHigh = 0, tblByte = 0, winReq = 0, winWrite = 0, rv;
   reg  [2:0]  eaAddrMode = 0;
   reg  [3:0]  regAddr = 0, eaPtrSel = 0, sel = 15;
   reg  [7:0]  page = 0;
   reg  [15:0] regWrData = 0, eaPtrValue = 0, eaNormalEa = 0, tblEa = 0;
   reg  [15:0] eaNormalPtrNext = 0, piv = 0, sum, lastExp = 0;
   reg  [31:0] r;
   wire [15:0] regRdData, eaOut, eaPtrWrData, tblData, winData;
   wire [23:0] tblAddr, progWord;
   wire [3:0]  eaPtrWrSel;
   wire        eaValid, eaPtrWrEn, eaRevUsed, tblValid, winValid, winRefused;
   integer     err_total = 0, check_count = 0, seed = 91202, i;
   brtr_agu dut_u (.*);
   brtr_prog_mem mem_u (.progAddr({page, tblEa}), .progWord(progWord));
   // Clock and hang guard.
   initial forever #5 mclk = ~mclk;
   initial #90000 give_verdict(1);
   function [15:0] rb(input [15:0] v);
      integer j;
      for (j = 0; j < 16; j = j + 1) rb[j] = v[15-j];
   endfunction
   task give_verdict(input integer x);
      err_total = err_total + x;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input [23:0] s, e, input [31:0] n);
      check_count = check_count + 1;
      err_total = err_total + (s !== e);
      if (s !== e) $display("ERROR %s exp %h seen %h", n, e, s);
   endtask
   task go(input [4:0] q);
      {regWrStb, regRdStb, eaReq, tblReq, winReq} <= q;
      @(posedge mclk);
      {regWrStb, regRdStb, eaReq, tblReq, winReq} <= 5'h00;
      @(negedge mclk);
   endtask
   task rg(input w, input [3:0] a, input [15:0] v);
      @(posedge mclk);
      {regAddr, regWrData} <= {a, v};
      go({w, !w, 3'b000});
      if (!w) chk(regRdData, v, "reg");
   endtask
   task ea(input w, x, b, input [2:0] m, input [3:0] s, input [15:0] p);
      r = $random(seed);
      @(posedge mclk);
      {eaIsWrite, eaIsXGen, eaIsByte, eaAddrMode, eaPtrSel} <= {w, x, b, m, s};
      {eaPtrValue, eaNormalEa, eaNormalPtrNext} <= {p, r};
      go(5'h04);
      sum = rb(rb(p & 16'hFFFE) + rb({piv[14:0], 1'b0})) & 16'hFFFE;
      rv = w && x && !b && (m == 3 || m == 5) && s == sel && sel != 15
         && piv[15];
      chk({eaValid, eaRevUsed}, {1'b1, rv}, "rev");
      lastExp = rv ? (m == 5 ? sum : p & 16'hFFFE) : r[31:16];
      chk(eaOut, lastExp, "ea");
      chk({eaPtrWrEn, eaPtrWrSel}, {m == 3 || m == 5, s}, "wsel");
      chk(eaPtrWrData, rv ? sum : r[15:0], "ptr");
   endtask
   // Defaults, reversal walk, random addressing, then table reads.
   initial begin
      repeat (10) @(posedge mclk);
      rst <= 0;
      rg(0, 0, 16'h0000);
      rg(0, 1, 16'h0F00);
      rg(0, 2, 16'h0000);
      rg(1, 10, 16'h1234);
      rg(0, 10, 16'h0000);
      piv = 16'h8008;
      sel = 2;
      rg(1, 0, piv);
      rg(0, 0, piv);
      rg(1, 1, 16'h0200);
      sum = 16'h1000;
      for (i = 0; i < 16; i = i + 1) begin
         ea(1, 1, 0, 3, sel, sum);
         chk(eaOut, {11'h080, i[0], i[1], i[2], i[3], 1'b0}, "ord");
      end
      r = $random(seed);
      piv = {1'b1, r[14:0]};
      rg(1, 0, piv);
      for (i = 0; i < 99; i = i + 1) begin
         if (i == 60) sel = 15;
         if (i == 60) rg(1, 1, 16'h0F00);
         r = $random(seed);
         ea(r[0] | r[1], r[1] | r[2], r[3] & r[4], r[5] ? (r[6] ? 3'h5 :
            3'h3) : r[9:7], r[10] ? sel : r[14:11], r[31:16]);
      end
      rg(0, 3, lastExp);
      for (i = 0; i < 40; i = i + 1) begin
         r = $random(seed);
         page = r[31:24];
         rg(1, 2, {8'h00, page});
         @(posedge mclk);
         {winWrite, tblHigh, tblByte, tblEa} <= r[18:0];
         go(5'h03);
         chk(tblAddr, {page, tblEa[15:1], 1'b0}, "adr");
         chk({tblValid, tblData}, {1'b1, !tblHigh ? (tblByte ? (tblEa[0] ?
            {8'h00, progWord[15:8]} : {8'h00, progWord[7:0]}) :
            progWord[15:0]) : (tblByte && tblEa[0]) ? 16'h0000 :
            {8'h00, progWord[23:16]}}, "tbl");
         chk({winValid, winRefused}, {!r[18], r[18]}, "win");
         if (!r[18]) chk(winData, progWord[15:0], "wdat");
         rg(0, 4, {tblEa[15:1], 1'b0});
      end
      give_verdict(0);
   end
endmodule // brtr_agu_tb_top
